//--- core/intc_consts.vh
// Constants for the interrupt priority and address-break controller
// Operation
// - Two control modes from two select bits
// - Priority bit 0 means level 0, 1 level 1
// - Nonmaskable and break requests ignore priority bits
// - Three-level masking from mode, mask bits, priorities
// - Nonmaskable highest, always accepted, edge selectable
// - Eight pins: falling, rising, both or level
// - Each source has its own vector number
// - Request may start transfer controller, CPU, both
// - Priority register A source bit mapping
// - Priority registers B, C, D source mapping
// - Break request when match flag and enable set
// - Match flag sets on enabled prefetch address hit
// - Match flag read-only, cleared by break exception
// - Break enable at bit 0, resets to 0
// - Break control bits 6..1 read zero
// - Three break address registers, low bit zero
// - Normal mode ignores address bits 23..16
// - Sense code 00 low,01 fall,10 rise,11 both
// - Pin request needs its enable bit set
// - Pin flag clears by zero write after one read
`ifndef INTC_CONSTS_VH
`define INTC_CONSTS_VH
`define ADDR_PRI_A      4'h0
`define ADDR_PRI_B      4'h1
`define ADDR_PRI_C      4'h2
`define ADDR_PRI_D      4'h3
`define ADDR_BRK_CTRL   4'h4
`define ADDR_BRK_HIGH   4'h5
`define ADDR_BRK_MID    4'h6
`define ADDR_BRK_LOW    4'h7
`define ADDR_SENSE_HIGH 4'h8
`define ADDR_SENSE_LOW  4'h9
`define ADDR_PIN_EN     4'ha
`define ADDR_PIN_FLAG   4'hb
`define ADDR_SYS_CTRL   4'hc
`define ADDR_PENDING    4'hd
`define SYS_MODE_LO     4
`define SYS_MODE_HI     5
`define SYS_NMI_EDGE    3
`define BRK_MATCH_BIT   7
`define BRK_ENABLE_BIT  0
`define PRI_RESET       8'h00
`define SYS_RESET       8'h00
`define PRI_A_RESV      8'h00
`define PRI_B_RESV      8'h31
`define PRI_C_RESV      8'h27
`define PRI_D_RESV      8'h3f
`define SENSE_LOW       2'b00
`define SENSE_FALL      2'b01
`define SENSE_RISE      2'b10
`define SENSE_BOTH      2'b11
`define VEC_NMI         7'h07
`define VEC_PIN0        7'h10
`define VEC_INTERNAL    7'h18
// Break vector sits past the sixteen internal sources so no source shares it
`define VEC_BREAK       7'h28
`define NUM_INT         16
`endif

//--- core/intc_core.v
// Interrupt controller: priority, masking, pin sensing, vectors and address break
//
// Local design decisions: the address map and the strobed register port.
`include "intc_consts.vh"
module intc_core (
  // Clock and reset
  input  wire        i_clock,
  input  wire        i_rst_b,
  // Register port
  input  wire [3:0]  i_addr,
  input  wire [7:0]  i_wdata,
  input  wire        i_wr,
  input  wire        i_rd,
  output reg  [7:0]  o_rdata,
  // Pins
  input  wire        i_nmi,
  input  wire [7:0]  i_pin_irq,
  // Internal peripheral requests, index k uses vector 24+k
  input  wire [15:0] i_int_req,
  input  wire [15:0] i_int_dtc_en,
  input  wire [15:0] i_int_cpu_en,
  // CPU state
  input  wire        i_ccr_i,
  input  wire        i_user_mask_bit,
  input  wire        i_advanced_mode,
  input  wire        i_prefetch,
  input  wire [23:0] i_prefetch_addr,
  input  wire        i_ack,
  input  wire [6:0]  i_ack_vector,
  // Requests to CPU and transfer controller
  output reg         o_irq,
  output reg  [6:0]  o_vector,
  output reg         o_dtc_req,
  output reg  [6:0]  o_dtc_vector
);
  reg  [7:0] priority_level_reg_a;
  reg  [7:0] priority_level_reg_b;
  reg  [7:0] priority_level_reg_c;
  reg  [7:0] priority_level_reg_d;
  reg  [7:0] system_control_register;
  reg        break_enable;
  reg        condition_match_flag;
  reg  [7:0] break_addr_high;
  reg  [7:0] break_addr_mid;
  reg  [6:0] break_addr_low;
  reg  [7:0] sense_control_high;
  reg  [7:0] sense_control_low;
  reg  [7:0] pin_irq_enable_reg;
  reg  [7:0] pin_request_flag;
  reg  [7:0] flag_read_one;
  reg  [7:0] pin_prev_reg;
  reg        nmi_prev_reg;
  reg        nmi_pend_reg;
  wire [15:0] sense_all = {sense_control_high, sense_control_low};
  wire [1:0] control_mode = {system_control_register[`SYS_MODE_HI],
                             system_control_register[`SYS_MODE_LO]};
  // Priority bit for internal source index 0..13; 14 and 15 stay at level 0
  function pri_int;
    input [3:0] k;
    begin
      case (k)
        4'h0: pri_int = priority_level_reg_b[7];
        4'h1: pri_int = priority_level_reg_b[6];
        4'h2: pri_int = priority_level_reg_b[3];
        4'h3: pri_int = priority_level_reg_b[2];
        4'h4: pri_int = priority_level_reg_b[1];
        4'h5: pri_int = priority_level_reg_c[7];
        4'h6: pri_int = priority_level_reg_c[6];
        4'h7: pri_int = priority_level_reg_c[4];
        4'h8: pri_int = priority_level_reg_c[3];
        4'h9: pri_int = priority_level_reg_d[7];
        4'ha: pri_int = priority_level_reg_d[6];
        4'hb: pri_int = priority_level_reg_a[2];
        4'hc: pri_int = priority_level_reg_a[1];
        4'hd: pri_int = priority_level_reg_a[0];
        default: pri_int = 1'b0;
      endcase
    end
  endfunction
  // Priority bit for pin n
  function pri_pin;
    input [2:0] n;
    begin
      case (n)
        3'd0: pri_pin = priority_level_reg_a[7];
        3'd1: pri_pin = priority_level_reg_a[6];
        3'd2, 3'd3: pri_pin = priority_level_reg_a[5];
        3'd4, 3'd5: pri_pin = priority_level_reg_a[4];
        default: pri_pin = priority_level_reg_a[3];
      endcase
    end
  endfunction
  // Pin edge/level detection
  wire [7:0] pin_event;
  wire [7:0] pin_level_mode;
  genvar g;
  generate
    for (g = 0; g < 8; g = g + 1) begin : pin_det
      wire [1:0] sc = sense_all[2*g+1:2*g];
      wire fall = pin_prev_reg[g] & ~i_pin_irq[g];
      wire rise = ~pin_prev_reg[g] & i_pin_irq[g];
      assign pin_level_mode[g] = (sc == `SENSE_LOW);
      assign pin_event[g] = (sc == `SENSE_LOW)  ? ~i_pin_irq[g] :
                            (sc == `SENSE_FALL) ? fall :
                            (sc == `SENSE_RISE) ? rise : (fall | rise);
    end
  endgenerate
  wire nmi_edge = system_control_register[`SYS_NMI_EDGE] ?
                  (~nmi_prev_reg & i_nmi) : (nmi_prev_reg & ~i_nmi);
  wire break_req = condition_match_flag & break_enable;
  wire [15:0] brk_cmp_hi = i_advanced_mode ? {break_addr_high, 8'h00}
                                           : 16'h0000;
  wire [23:0] pf_mask = i_advanced_mode ? i_prefetch_addr
                                        : {8'h00, i_prefetch_addr[15:0]};
  wire brk_hit = i_prefetch & break_enable & (pf_mask[23:1] ==
                 {brk_cmp_hi[15:8], break_addr_mid, break_addr_low});
  // Pending pin requests are gated by the enable bits
  wire [7:0]  pin_pend = pin_request_flag & pin_irq_enable_reg;
  wire [15:0] int_cpu  = i_int_req & i_int_cpu_en;
  wire [15:0] int_dtc  = i_int_req & i_int_dtc_en;
  // Mask levels: mode 0 uses I only; mode 2 uses I for level 0, I and UI for level 1
  reg        accept_lvl0;
  reg        accept_lvl1;
  always @* begin
    if (control_mode == 2'b10) begin
      accept_lvl0 = ~i_ccr_i;
      accept_lvl1 = ~(i_ccr_i & i_user_mask_bit);
    end else begin
      accept_lvl0 = ~i_ccr_i;
      accept_lvl1 = ~i_ccr_i;
    end
  end
  // Selection: NMI, break, then level 1, then level 0, lowest vector first
  reg        sel_valid;
  reg  [6:0] sel_vec;
  reg        dtc_valid;
  reg  [6:0] dtc_vec;
  reg        found1;
  reg        found0;
  reg  [6:0] vec1;
  reg  [6:0] vec0;
  integer    i;
  always @* begin
    found1 = 1'b0;
    found0 = 1'b0;
    vec1 = 7'h00;
    vec0 = 7'h00;
    dtc_valid = 1'b0;
    dtc_vec = 7'h00;
    for (i = 15; i >= 0; i = i - 1) begin
      if (int_cpu[i] && pri_int(i[3:0])) begin
        found1 = 1'b1;
        vec1 = `VEC_INTERNAL + i[6:0];
      end
      if (int_cpu[i] && !pri_int(i[3:0])) begin
        found0 = 1'b1;
        vec0 = `VEC_INTERNAL + i[6:0];
      end
      if (int_dtc[i]) begin
        dtc_valid = 1'b1;
        dtc_vec = `VEC_INTERNAL + i[6:0];
      end
    end
    for (i = 7; i >= 0; i = i - 1) begin
      if (pin_pend[i] && pri_pin(i[2:0])) begin
        found1 = 1'b1;
        vec1 = `VEC_PIN0 + i[6:0];
      end
      if (pin_pend[i] && !pri_pin(i[2:0])) begin
        found0 = 1'b1;
        vec0 = `VEC_PIN0 + i[6:0];
      end
    end
    if (nmi_pend_reg) begin
      sel_valid = 1'b1;
      sel_vec = `VEC_NMI;
    end else if (break_req) begin
      sel_valid = 1'b1;
      sel_vec = `VEC_BREAK;
    end else if (found1 && accept_lvl1) begin
      sel_valid = 1'b1;
      sel_vec = vec1;
    end else if (found0 && accept_lvl0) begin
      sel_valid = 1'b1;
      sel_vec = vec0;
    end else begin
      sel_valid = 1'b0;
      sel_vec = 7'h00;
    end
  end
  wire ack_pin_hit = i_ack && (i_ack_vector >= `VEC_PIN0) && (i_ack_vector < `VEC_INTERNAL);
  wire [2:0] ack_pin = i_ack_vector[2:0];
  // Decoded strobes, each used by a single process below
  wire       wr_pin_flag = i_wr && (i_addr == `ADDR_PIN_FLAG);
  wire       rd_pin_flag = i_rd && (i_addr == `ADDR_PIN_FLAG);
  wire       ack_nmi     = i_ack && (i_ack_vector == `VEC_NMI);
  wire       ack_break   = i_ack && (i_ack_vector == `VEC_BREAK);
  integer    j;

  // Read data; an idle cycle returns zero so several slaves can be OR-ed
  reg  [7:0] rdata_next;
  always @* begin
    rdata_next = 8'h00;
    if (i_rd) begin
      if (i_addr == `ADDR_PRI_A)
        rdata_next = priority_level_reg_a;
      else if (i_addr == `ADDR_PRI_B)
        rdata_next = priority_level_reg_b;
      else if (i_addr == `ADDR_PRI_C)
        rdata_next = priority_level_reg_c;
      else if (i_addr == `ADDR_PRI_D)
        rdata_next = priority_level_reg_d;
      else if (i_addr == `ADDR_BRK_CTRL)
        rdata_next = {condition_match_flag, 6'h00, break_enable};
      else if (i_addr == `ADDR_BRK_HIGH)
        rdata_next = break_addr_high;
      else if (i_addr == `ADDR_BRK_MID)
        rdata_next = break_addr_mid;
      else if (i_addr == `ADDR_BRK_LOW)
        rdata_next = {break_addr_low, 1'b0};
      else if (i_addr == `ADDR_SENSE_HIGH)
        rdata_next = sense_control_high;
      else if (i_addr == `ADDR_SENSE_LOW)
        rdata_next = sense_control_low;
      else if (i_addr == `ADDR_PIN_EN)
        rdata_next = pin_irq_enable_reg;
      else if (i_addr == `ADDR_PIN_FLAG)
        rdata_next = pin_request_flag;
      else if (i_addr == `ADDR_SYS_CTRL)
        rdata_next = system_control_register;
      else if (i_addr == `ADDR_PENDING)
        rdata_next = {sel_valid, sel_vec};
      else
        rdata_next = 8'h00;
    end
  end

  // Edge history starts at the idle high level so no false edge follows reset
  always @(posedge i_clock or negedge i_rst_b) begin
    if (!i_rst_b) begin
      pin_prev_reg <= 8'hff;
      nmi_prev_reg <= 1'b1;
    end else begin
      pin_prev_reg <= i_pin_irq;
      nmi_prev_reg <= i_nmi;
    end
  end

  // Nonmaskable pending: a new edge in the acknowledge cycle is not lost
  always @(posedge i_clock or negedge i_rst_b) begin
    if (!i_rst_b)
      nmi_pend_reg <= 1'b0;
    else if (nmi_edge)
      nmi_pend_reg <= 1'b1;
    else if (ack_nmi)
      nmi_pend_reg <= 1'b0;
  end

  // Match flag: reset to 0 although software may not rely on its reset value.
  // A hit in the acknowledge cycle wins, so a second break is not dropped.
  always @(posedge i_clock or negedge i_rst_b) begin
    if (!i_rst_b)
      condition_match_flag <= 1'b0;
    else if (brk_hit)
      condition_match_flag <= 1'b1;
    else if (ack_break)
      condition_match_flag <= 1'b0;
  end

  // Pin flags: a zero write clears only after a read saw the flag set, and a
  // new event in the same cycle wins. Level-mode flags survive the acknowledge
  // while the pin is still low, since the request is still being asserted.
  always @(posedge i_clock or negedge i_rst_b) begin
    if (!i_rst_b) begin
      pin_request_flag <= 8'h00;
      flag_read_one    <= 8'h00;
    end else begin
      for (j = 0; j < 8; j = j + 1) begin
        if (pin_event[j])
          pin_request_flag[j] <= 1'b1;
        else if (wr_pin_flag && !i_wdata[j] && flag_read_one[j]) begin
          pin_request_flag[j] <= 1'b0;
          flag_read_one[j]    <= 1'b0;
        end else if (ack_pin_hit && ack_pin == j[2:0] &&
                     (!pin_level_mode[j] || i_pin_irq[j]))
          pin_request_flag[j] <= 1'b0;
        if (rd_pin_flag && pin_request_flag[j])
          flag_read_one[j] <= 1'b1;
      end
    end
  end

  // Priority levels; reserved bits are held at zero whatever is written
  always @(posedge i_clock or negedge i_rst_b) begin
    if (!i_rst_b) begin
      priority_level_reg_a <= `PRI_RESET;
      priority_level_reg_b <= `PRI_RESET;
      priority_level_reg_c <= `PRI_RESET;
      priority_level_reg_d <= `PRI_RESET;
    end else if (i_wr) begin
      if (i_addr == `ADDR_PRI_A)
        priority_level_reg_a <= i_wdata;
      else if (i_addr == `ADDR_PRI_B)
        priority_level_reg_b <= i_wdata & ~`PRI_B_RESV;
      else if (i_addr == `ADDR_PRI_C)
        priority_level_reg_c <= i_wdata & ~`PRI_C_RESV;
      else if (i_addr == `ADDR_PRI_D)
        priority_level_reg_d <= i_wdata & ~`PRI_D_RESV;
    end
  end

  // Break enable and break address
  always @(posedge i_clock or negedge i_rst_b) begin
    if (!i_rst_b) begin
      break_enable    <= 1'b0;
      break_addr_high <= 8'h00;
      break_addr_mid  <= 8'h00;
      break_addr_low  <= 7'h00;
    end else if (i_wr) begin
      if (i_addr == `ADDR_BRK_CTRL)
        break_enable <= i_wdata[`BRK_ENABLE_BIT];
      else if (i_addr == `ADDR_BRK_HIGH)
        break_addr_high <= i_wdata;
      else if (i_addr == `ADDR_BRK_MID)
        break_addr_mid <= i_wdata;
      else if (i_addr == `ADDR_BRK_LOW)
        break_addr_low <= i_wdata[7:1];
    end
  end

  // Pin sensing, pin enables and system control
  always @(posedge i_clock or negedge i_rst_b) begin
    if (!i_rst_b) begin
      sense_control_high      <= 8'h00;
      sense_control_low       <= 8'h00;
      pin_irq_enable_reg      <= 8'h00;
      system_control_register <= `SYS_RESET;
    end else if (i_wr) begin
      if (i_addr == `ADDR_SENSE_HIGH)
        sense_control_high <= i_wdata;
      else if (i_addr == `ADDR_SENSE_LOW)
        sense_control_low <= i_wdata;
      else if (i_addr == `ADDR_PIN_EN)
        pin_irq_enable_reg <= i_wdata;
      else if (i_addr == `ADDR_SYS_CTRL)
        system_control_register <= i_wdata;
    end
  end

  // CPU side outputs; registered so the vector never glitches while it stands
  always @(posedge i_clock or negedge i_rst_b) begin
    if (!i_rst_b) begin
      o_irq    <= 1'b0;
      o_vector <= 7'h00;
      o_rdata  <= 8'h00;
    end else begin
      o_irq    <= sel_valid;
      o_vector <= sel_vec;
      o_rdata  <= rdata_next;
    end
  end

  // Transfer controller outputs, independent of the CPU mask
  always @(posedge i_clock or negedge i_rst_b) begin
    if (!i_rst_b) begin
      o_dtc_req    <= 1'b0;
      o_dtc_vector <= 7'h00;
    end else begin
      o_dtc_req    <= dtc_valid;
      o_dtc_vector <= dtc_vec;
    end
  end
endmodule

//--- test/cpu_core_model.sv
// Behavioural CPU core that accepts requests and acknowledges them
module cpu_core_model #(
  parameter LAG = 3
) (
  // Clock and reset
  input  wire       i_clock,
  input  wire       i_rst_b,
  // Request side
  input  wire       i_irq,
  input  wire [6:0] i_vector,
  input  wire       i_accept,
  // Acknowledge side
  output reg        o_ack,
  output reg  [6:0] o_ack_vector
);
  timeunit 1ns;
  timeprecision 1ps;
  reg [2:0] gap_reg;
  // The gap lets a cleared source drop before a stale vector could be taken again
  always @(posedge i_clock or negedge i_rst_b) begin
    if (!i_rst_b) begin
      o_ack        <= 1'b0;
      o_ack_vector <= 7'h00;
      gap_reg      <= 3'h0;
    end else begin
      o_ack <= 1'b0;
      if (gap_reg != 3'h0) gap_reg <= gap_reg - 3'h1;
      else if (i_irq && i_accept) begin
        o_ack        <= 1'b1;
        o_ack_vector <= i_vector;
        gap_reg      <= LAG[2:0];
      end
    end
  end
endmodule

//--- test/intc_core_sva.sv
// Port-level assertions for the interrupt controller
`include "intc_consts.vh"
module intc_core_sva (
  // Clock and reset
  input wire        i_clock,
  input wire        i_rst_b,
  // Register port
  input wire [3:0]  i_addr,
  input wire [7:0]  i_wdata,
  input wire        i_wr,
  input wire        i_rd,
  input wire [7:0]  o_rdata,
  // CPU and transfer controller side
  input wire        i_ccr_i,
  input wire        i_user_mask_bit,
  input wire [15:0] i_int_req,
  input wire [15:0] i_int_dtc_en,
  input wire        i_ack,
  input wire [6:0]  i_ack_vector,
  input wire        o_irq,
  input wire [6:0]  o_vector,
  input wire        o_dtc_req,
  input wire [6:0]  o_dtc_vector
);
  timeunit 1ns;
  timeprecision 1ps;
  reg brk_en_reg;
  reg mode2_reg;
  default clocking cb @(posedge i_clock); endclocking
  default disable iff (!i_rst_b);
  // Shadows of the break enable and mode select, rebuilt from bus writes
  always @(posedge i_clock or negedge i_rst_b) begin
    if (!i_rst_b) begin
      brk_en_reg <= 1'b0;
      mode2_reg  <= 1'b0;
    end else if (i_wr) begin
      if (i_addr == `ADDR_BRK_CTRL) brk_en_reg <= i_wdata[0];
      if (i_addr == `ADDR_SYS_CTRL) mode2_reg <= (i_wdata[5:4] == 2'b10);
    end
  end
  a_rdata_quiet: assert property (!$past(i_rd) |-> o_rdata == 8'h00)
    else $error("read data not zero outside a read");
  a_ctrl_resv: assert property ($past(i_rd && i_addr == `ADDR_BRK_CTRL) |->
    o_rdata[6:1] == 6'h00) else $error("break control reserved bits not zero");
  a_ctrl_enable: assert property ($past(i_rd && i_addr == `ADDR_BRK_CTRL) |->
    o_rdata[0] == $past(brk_en_reg)) else $error("break enable readback wrong");
  a_low_bit0: assert property ($past(i_rd && i_addr == `ADDR_BRK_LOW) |->
    !o_rdata[0]) else $error("break address low bit not zero");
  a_pri_resv: assert property ($past(i_rd) |-> (o_rdata &
    ($past(i_addr) == `ADDR_PRI_B ? `PRI_B_RESV : $past(i_addr) == `ADDR_PRI_C ?
    `PRI_C_RESV : $past(i_addr) == `ADDR_PRI_D ? `PRI_D_RESV : 8'h00)) == 8'h00)
    else $error("reserved priority bits not zero");
  a_mask_all: assert property ($past(i_ccr_i && (!mode2_reg || i_user_mask_bit)) &&
    o_irq |-> o_vector == `VEC_NMI) else $error("masked request reached the CPU");
  a_break_gate: assert property (o_irq && o_vector == `VEC_BREAK |->
    $past(brk_en_reg)) else $error("break request without enable");
  a_nmi_clear: assert property (i_ack && i_ack_vector == `VEC_NMI |->
    ##2 !(o_irq && o_vector == `VEC_NMI)) else $error("nonmaskable request not cleared");
  a_brk_clear: assert property (i_ack && i_ack_vector == `VEC_BREAK |->
    ##2 !(o_irq && o_vector == `VEC_BREAK)) else $error("break flag not cleared");
  a_dtc_cause: assert property (o_dtc_req |-> |(($past(i_int_req & i_int_dtc_en) >>
    (o_dtc_vector - `VEC_INTERNAL)) & 16'h0001)) else $error("transfer request without source");
endmodule
bind intc_core intc_core_sva intc_core_sva_i (.*);

//--- test/testbench.sv
// Self-checking bench for the interrupt controller
`include "intc_consts.vh"
`define CHK(n, e, g) begin n_compared++; if ((g) !== (e)) begin err_count++; \
  $display("unexpected %s exp %h got %h", n, e, g); end end
module testbench;
  timeunit 1ns;
  timeprecision 1ps;
  logic        i_clock = 0;
  logic        i_rst_b = 0;
  logic [3:0]  i_addr = 4'h0;
  logic [7:0]  i_wdata = 8'h00;
  logic        i_wr = 0;
  logic        i_rd = 0;
  logic        i_nmi = 1;
  logic [7:0]  i_pin_irq = 8'hff;
  logic [15:0] i_int_req = 16'h0000;
  logic [15:0] i_int_dtc_en = 16'h0000;
  logic [15:0] i_int_cpu_en = 16'h0000;
  logic        i_ccr_i = 1;
  logic        i_user_mask_bit = 1;
  logic        i_advanced_mode = 1;
  logic        i_prefetch = 0;
  logic [23:0] i_prefetch_addr = 24'h000000;
  logic        accept = 0;
  logic [1:0]  c;
  wire         i_ack;
  wire  [6:0]  i_ack_vector;
  wire  [7:0]  o_rdata;
  wire         o_irq;
  wire  [6:0]  o_vector;
  wire         o_dtc_req;
  wire  [6:0]  o_dtc_vector;
  int          err_count = 0;
  int          n_compared = 0;
  int          cycles = 0;
  logic [3:0]  ta [11] = '{4'h0, 4'h1, 4'h2, 4'h3, 4'h4, 4'h5, 4'h6, 4'h7, 4'h8, 4'ha, 4'hf};
  logic [7:0]  tw [11] = '{8'hff, 8'hce, 8'hd8, 8'hc0, 8'hff, 8'h12, 8'h34, 8'h57, 8'ha5,
                           8'h3c, 8'hab};
  logic [7:0]  te [11] = '{8'hff, 8'hce, 8'hd8, 8'hc0, 8'h01, 8'h12, 8'h34, 8'h56, 8'ha5,
                           8'h3c, 8'h00};
  logic [1:0]  codes [4] = '{2'h1, 2'h2, 2'h3, 2'h0};
  intc_core intc_core_i (.*);
  cpu_core_model #(.LAG(3)) cpu_core_model_i (.i_clock(i_clock), .i_rst_b(i_rst_b),
    .i_irq(o_irq), .i_vector(o_vector), .i_accept(accept), .o_ack(i_ack),
    .o_ack_vector(i_ack_vector));
  initial forever #2 i_clock = ~i_clock;
  task complete_run();
    if (err_count == 0 && n_compared > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  always @(posedge i_clock) begin
    cycles <= cycles + 1;
    if (cycles == 3000) begin
      err_count++;
      complete_run();
    end
  end
  task cyc(input int n); repeat (n) @(posedge i_clock); endtask
  task wr(input [3:0] a, input [7:0] d);
    @(posedge i_clock); i_addr <= a; i_wdata <= d; i_wr <= 1;
    @(posedge i_clock); i_wr <= 0;
  endtask
  task rd(input [3:0] a, input [7:0] e);
    @(posedge i_clock); i_addr <= a; i_rd <= 1;
    @(posedge i_clock); i_rd <= 0;
    @(negedge i_clock); `CHK("rdata", e, o_rdata)
  endtask
  task irq(input x, input [6:0] v);
    @(negedge i_clock); `CHK("irq", x, o_irq)
    if (x) `CHK("vector", v, o_vector)
  endtask
  task pf(input [23:0] a);
    @(posedge i_clock); i_prefetch <= 1; i_prefetch_addr <= a;
    @(posedge i_clock); i_prefetch <= 0;
  endtask
  task serve(); accept <= 1; cyc(12); accept <= 0; cyc(2); endtask
  initial begin
    cyc(10);
    i_rst_b <= 1;
    for (int a = 0; a < 16; a++) rd(a[3:0], 8'h00);
    // Reserved priority bits are written as zero, as software must
    for (int k = 0; k < 11; k++) begin
      wr(ta[k], tw[k]);
      rd(ta[k], te[k]);
    end
    // Break addresses point at instruction starts
    i_ccr_i <= 0;
    pf(24'h993456); cyc(1); irq(0, 7'h00);
    pf(24'h123457); cyc(1); irq(1, `VEC_BREAK);
    rd(`ADDR_BRK_CTRL, 8'h81);
    serve(); rd(`ADDR_BRK_CTRL, 8'h01);
    i_advanced_mode <= 0;
    pf(24'h773456); cyc(1); irq(1, `VEC_BREAK);
    rd(`ADDR_PENDING, {1'b1, `VEC_BREAK});
    wr(`ADDR_BRK_CTRL, 8'h00); cyc(1); irq(0, 7'h00);
    rd(`ADDR_BRK_CTRL, 8'h80);
    wr(`ADDR_BRK_CTRL, 8'h01); serve(); wr(`ADDR_BRK_CTRL, 8'h00);
    pf(24'h773456); cyc(1); rd(`ADDR_BRK_CTRL, 8'h00);
    // Pins 0 and 2 on falling edges, both first at level 1
    wr(`ADDR_SENSE_LOW, 8'h11); wr(`ADDR_PIN_EN, 8'h05); wr(`ADDR_SYS_CTRL, 8'h20);
    i_pin_irq <= 8'hfa; cyc(3); irq(1, 7'h10);
    wr(`ADDR_PRI_A, 8'h20); cyc(1); irq(1, 7'h12);
    i_ccr_i <= 1; i_user_mask_bit <= 0; cyc(2); irq(1, 7'h12);
    i_user_mask_bit <= 1; cyc(2); irq(0, 7'h00);
    i_nmi <= 0; cyc(3); irq(1, `VEC_NMI);
    serve(); irq(0, 7'h00);
    i_ccr_i <= 0; serve(); irq(0, 7'h00);
    rd(`ADDR_PIN_FLAG, 8'h00);
    // A zero write without a prior read of one leaves the flag alone
    i_ccr_i <= 1; i_pin_irq <= 8'hff; cyc(2); i_pin_irq <= 8'hfe; cyc(3);
    wr(`ADDR_PIN_FLAG, 8'h00); rd(`ADDR_PIN_FLAG, 8'h01);
    wr(`ADDR_PIN_FLAG, 8'h00); rd(`ADDR_PIN_FLAG, 8'h00);
    i_pin_irq <= 8'hff; cyc(3);
    for (int k = 0; k < 4; k++) begin
      c = codes[k];
      wr(`ADDR_SENSE_LOW, {6'h00, c});
      i_pin_irq <= 8'hfe; cyc(3); rd(`ADDR_PIN_FLAG, {7'h00, c != 2'h2});
      wr(`ADDR_PIN_FLAG, 8'h00);
      i_pin_irq <= 8'hff; cyc(3); rd(`ADDR_PIN_FLAG, {7'h00, c != 2'h1});
      wr(`ADDR_PIN_FLAG, 8'h00);
    end
    i_ccr_i <= 0; wr(`ADDR_PIN_EN, 8'h00);
    i_pin_irq <= 8'hfe; cyc(3); irq(0, 7'h00);
    wr(`ADDR_PIN_EN, 8'h01); cyc(1); irq(1, `VEC_PIN0);
    i_int_req <= 16'h0028; i_int_dtc_en <= 16'h0028; i_int_cpu_en <= 16'h0028; cyc(3);
    @(negedge i_clock);
    `CHK("dtc req", 1'b1, o_dtc_req)
    `CHK("dtc vector", 7'h1b, o_dtc_vector)
    irq(1, 7'h1b);
    wr(`ADDR_PRI_B, 8'h00); cyc(1); irq(1, 7'h1d);
    i_int_req <= 16'h0000; i_ccr_i <= 1; cyc(3);
    complete_run();
  end
endmodule
